// ---- include/mirror_spi_defs.svh ----
`ifndef MIRROR_SPI_DEFS_SVH
`define MIRROR_SPI_DEFS_SVH

`define FRAME_BITS 16
`define REG_MIRROR_HEATER 2'h0
`define REG_PWM_IN_1_ROUTE 2'h1
`define REG_BRIDGE_LAMP 2'h2
`define REG_PWM_IN_2_ROUTE 2'h3
`define CTRL_RESET 10'h000
`define SENSE_NONE 3'h0
`define SENSE_BRIDGE4_HIGH 3'h3
`define SENSE_HEATER 3'h4
`define BIT_ADDR_HI 1
`define BIT_CLEAR 2
`define BIT_SENSE_LO 3
`define BIT_SENSE_HI 5
`define BIT_DATA_LO 6
`define BIT_DATA_HI 15
`define BIT_HEATER_ON 9
`define BIT_PWM_HEATER 15
`define BIT_PWM_LAMP_A 14
`define BIT_PWM_LAMP_B 12
`define BIT_BRIDGE_LO 10
`define BIT_LAMP_A_ON 9
`define BIT_LAMP_B_ON 7
`define BIT_OPL_HI 7
`define BIT_OPL_LO 6
`define BIT_TEST_HI 8
`define BIT_TEST_LO 6

`endif

// ---- include/mirror_spi_pkg.sv ----
package mirror_spi_pkg;
   typedef enum logic [1:0] {
      REG_HEATER,
      REG_PWM_IN_1,
      REG_BRIDGE,
      REG_PWM_IN_2
   } reg_sel_t;
   typedef enum logic [1:0] {
      SENSE_OFF,
      SENSE_BRIDGE4,
      SENSE_HEATER_SW
   } sense_route_t;
   typedef enum logic [1:0] {
      LINK_IDLE,
      LINK_FRAME,
      LINK_COMMIT
   } link_state_t;
endpackage : mirror_spi_pkg

// ---- verilog/pin_sync.sv ----
module pin_sync (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic pin_i,
   input wire logic init_i,
   output logic level_o,
   output logic rise_o,
   output logic fall_o
);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic level_r;

   // Stages start at the pin's idle level, so leaving reset makes no edge.
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         s1_r <= init_i;
         s2_r <= init_i;
         s3_r <= init_i;
      end else begin
         s1_r <= pin_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // A change counts only once the second and third stages agree.
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         level_r <= init_i;
      end else if (s2_r == s3_r) begin
         level_r <= s3_r;
      end
   end

   assign level_o = level_r;
   assign rise_o = (s2_r == s3_r) && s3_r && !level_r;
   assign fall_o = (s2_r == s3_r) && !s3_r && level_r;
endmodule : pin_sync

// ---- verilog/frame_shifter.sv ----
module frame_shifter (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic load_i,
   input wire logic [15:0] load_data_i,
   input wire logic shift_i,
   input wire logic serial_bit_i,
   input wire logic present_i,
   output logic [15:0] word_o,
   output logic out_bit_o
);
   logic [15:0] shift_r;
   logic out_r;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         shift_r <= 16'h0000;
      end else if (load_i) begin
         shift_r <= load_data_i;
      end else if (shift_i) begin
         shift_r <= {shift_r[14:0], serial_bit_i};
      end
   end

   // Presents the current MSB; the top captures it on rising clock edges.
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         out_r <= 1'b0;
      end else if (load_i) begin
         out_r <= load_data_i[15];
      end else if (present_i) begin
         out_r <= shift_r[15];
      end
   end

   assign word_o = shift_r;
   assign out_bit_o = out_r;
endmodule : frame_shifter

// ---- verilog/mirror_driver_spi_control.sv ----
`include "mirror_spi_defs.svh"

module mirror_driver_spi_control (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic logic_supply_ok_i,
   input wire logic wake_enable_i,
   input wire logic select_n_i,
   input wire logic serial_clk_i,
   input wire logic serial_in_i,
   input wire logic pwm_in_1_i,
   input wire logic pwm_in_2_i,
   input wire logic [15:0] status_word_0_i,
   input wire logic [15:0] status_word_1_i,
   input wire logic [15:0] status_word_2_i,
   input wire logic [15:0] status_word_3_i,
   output logic serial_out_o,
   output logic serial_out_oe_n_o,
   output logic outputs_oe_n_o,
   output logic heater_drive_o,
   output logic lamp_a_drive_o,
   output logic lamp_b_drive_o,
   output logic [5:0] bridge_drive_o,
   output logic [2:0] openload_pullup_o,
   output logic test_mode_o,
   output mirror_spi_pkg::sense_route_t sense_route_o,
   output logic [3:0] status_clear_o
);
   import mirror_spi_pkg::*;

   logic supply_lvl;
   logic supply_rise;
   logic wake_lvl;
   logic wake_rise;
   logic sel_lvl;
   logic sel_rise;
   logic sel_fall;
   logic sclk_rise;
   logic sclk_fall;
   logic sdi_lvl;
   logic por;
   logic [15:0] shift_word;
   logic shift_bit;
   link_state_t state_r;
   logic [4:0] bit_count_r;
   logic [9:0] heater_reg_r;
   logic [9:0] pwm_in_1_reg_r;
   logic [9:0] bridge_reg_r;
   logic [9:0] pwm_in_2_reg_r;
   logic [2:0] sense_sel_r;
   logic clear_pending_r;
   logic [1:0] status_sel_r;
   logic [1:0] clear_sel_r;
   logic [15:0] status_mux;
   logic heater_nxt;
   logic lamp_a_nxt;
   logic lamp_b_nxt;

   function automatic logic drive_of(input logic on_bit, input logic pick1,
                                     input logic pick2, input logic p1,
                                     input logic p2);
      drive_of = (pick1 & p1) | (pick2 & p2) | (on_bit & ~pick1 & ~pick2);
   endfunction : drive_of

   pin_sync supply_sync (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .pin_i(logic_supply_ok_i),
      .init_i(1'b0), .level_o(supply_lvl), .rise_o(supply_rise),
      .fall_o()
   );
   pin_sync wake_sync (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .pin_i(wake_enable_i),
      .init_i(1'b0), .level_o(wake_lvl), .rise_o(wake_rise), .fall_o()
   );
   pin_sync sel_sync (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .pin_i(select_n_i),
      .init_i(1'b1), .level_o(sel_lvl), .rise_o(sel_rise),
      .fall_o(sel_fall)
   );
   pin_sync sclk_sync (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .pin_i(serial_clk_i),
      .init_i(1'b0), .level_o(), .rise_o(sclk_rise),
      .fall_o(sclk_fall)
   );
   pin_sync sdi_sync (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .pin_i(serial_in_i),
      .init_i(1'b0), .level_o(sdi_lvl), .rise_o(), .fall_o()
   );

   // Supply rise and wake rise both clear every stored setting and the link state; the shift register keeps its word.
   assign por = supply_rise | wake_rise;

   always_comb begin
      case (status_sel_r)
         2'h0: status_mux = status_word_0_i;
         2'h1: status_mux = status_word_1_i;
         2'h2: status_mux = status_word_2_i;
         2'h3: status_mux = status_word_3_i;
         default: status_mux = 16'h0000;
      endcase
   end

   // Present data on the rise; sample on the fall.
   frame_shifter shifter (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .load_i(state_r == LINK_IDLE && sel_fall && wake_lvl),
      .load_data_i(status_mux),
      .shift_i(state_r == LINK_FRAME && sclk_fall),
      .serial_bit_i(sdi_lvl),
      .present_i(state_r == LINK_FRAME && sclk_rise),
      .word_o(shift_word),
      .out_bit_o(shift_bit)
   );

   always_ff @(posedge clock_i) begin
      if (!rst_n_i || por || !wake_lvl) begin
         state_r <= LINK_IDLE;
      end else begin
         case (state_r)
            LINK_IDLE: if (sel_fall) state_r <= LINK_FRAME;
            LINK_FRAME: if (sel_rise) state_r <= LINK_COMMIT;
            LINK_COMMIT: state_r <= LINK_IDLE;
            default: state_r <= LINK_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i || state_r == LINK_IDLE) begin
         bit_count_r <= 5'h00;
      end else if (state_r == LINK_FRAME && sclk_fall &&
                   bit_count_r != 5'h1F) begin
         bit_count_r <= bit_count_r + 5'h01;
      end
   end

   // A frame of at least 16 bits commits its last 16; longer frames
   // simply pass older bits onward, which is what a daisy chain needs.
   always_ff @(posedge clock_i) begin
      if (!rst_n_i || por) begin
         heater_reg_r <= `CTRL_RESET;
         pwm_in_1_reg_r <= `CTRL_RESET;
         bridge_reg_r <= `CTRL_RESET;
         pwm_in_2_reg_r <= `CTRL_RESET;
         sense_sel_r <= `SENSE_NONE;
         status_sel_r <= 2'h0;
      end else if (state_r == LINK_COMMIT && bit_count_r >= 5'h10) begin
         case (shift_word[`BIT_ADDR_HI:0])
            `REG_MIRROR_HEATER:
               heater_reg_r <= shift_word[`BIT_DATA_HI:`BIT_DATA_LO];
            `REG_PWM_IN_1_ROUTE:
               pwm_in_1_reg_r <= shift_word[`BIT_DATA_HI:`BIT_DATA_LO];
            `REG_BRIDGE_LAMP:
               bridge_reg_r <= shift_word[`BIT_DATA_HI:`BIT_DATA_LO];
            `REG_PWM_IN_2_ROUTE:
               pwm_in_2_reg_r <= shift_word[`BIT_DATA_HI:`BIT_DATA_LO];
            default: heater_reg_r <= heater_reg_r;
         endcase
         sense_sel_r <= shift_word[`BIT_SENSE_HI:`BIT_SENSE_LO];
         status_sel_r <= shift_word[`BIT_ADDR_HI:0];
      end
   end // Values otherwise hold indefinitely.

   // The clear takes effect at the end of the next frame of at least 16 bits.
   always_ff @(posedge clock_i) begin
      if (!rst_n_i || por) begin
         clear_pending_r <= 1'b0;
         clear_sel_r <= 2'h0;
         status_clear_o <= 4'h0;
      end else begin
         status_clear_o <= 4'h0;
         if (state_r == LINK_COMMIT && bit_count_r >= 5'h10) begin
            if (clear_pending_r) begin
               status_clear_o <= 4'h1 << clear_sel_r;
            end
            clear_pending_r <= shift_word[`BIT_CLEAR];
            clear_sel_r <= shift_word[`BIT_ADDR_HI:0];
         end
      end
   end

   // Indices are bit positions minus the data field base of 6.
   assign heater_nxt = drive_of(heater_reg_r[`BIT_HEATER_ON - 6],
                                pwm_in_1_reg_r[`BIT_PWM_HEATER - 6],
                                pwm_in_2_reg_r[`BIT_PWM_HEATER - 6],
                                pwm_in_1_i, pwm_in_2_i);
   assign lamp_a_nxt = drive_of(bridge_reg_r[`BIT_LAMP_A_ON - 6],
                                pwm_in_1_reg_r[`BIT_PWM_LAMP_A - 6],
                                pwm_in_2_reg_r[`BIT_PWM_LAMP_A - 6],
                                pwm_in_1_i, pwm_in_2_i);
   assign lamp_b_nxt = drive_of(bridge_reg_r[`BIT_LAMP_B_ON - 6],
                                pwm_in_1_reg_r[`BIT_PWM_LAMP_B - 6],
                                pwm_in_2_reg_r[`BIT_PWM_LAMP_B - 6],
                                pwm_in_1_i, pwm_in_2_i);

   always_ff @(posedge clock_i) begin
      if (!rst_n_i || por || !wake_lvl || !supply_lvl) begin
         heater_drive_o <= 1'b0;
         lamp_a_drive_o <= 1'b0;
         lamp_b_drive_o <= 1'b0;
         bridge_drive_o <= 6'h00;
         openload_pullup_o <= 3'h0;
         test_mode_o <= 1'b0;
         sense_route_o <= SENSE_OFF;
         outputs_oe_n_o <= 1'b1;
      end else begin
         heater_drive_o <= heater_nxt;
         lamp_a_drive_o <= lamp_a_nxt;
         lamp_b_drive_o <= lamp_b_nxt;
         bridge_drive_o <= bridge_reg_r[9:4];
         openload_pullup_o <= {pwm_in_2_reg_r[`BIT_OPL_LO - 6],
                               pwm_in_2_reg_r[`BIT_OPL_HI - 6],
                               pwm_in_1_reg_r[`BIT_OPL_HI - 6]};
         test_mode_o <= |heater_reg_r[2:0] |
                        pwm_in_1_reg_r[`BIT_TEST_LO - 6];
         case (sense_sel_r)
            `SENSE_BRIDGE4_HIGH: sense_route_o <= SENSE_BRIDGE4;
            `SENSE_HEATER: sense_route_o <= SENSE_HEATER_SW;
            default: sense_route_o <= SENSE_OFF;
         endcase
         outputs_oe_n_o <= 1'b0;
      end
   end

   // Only a selected device drives the shared line.
   always_ff @(posedge clock_i) begin
      if (!rst_n_i || por || !wake_lvl || sel_lvl) begin
         serial_out_oe_n_o <= 1'b1;
         serial_out_o <= 1'b0;
      end else if (state_r == LINK_FRAME) begin
         serial_out_oe_n_o <= 1'b0;
         serial_out_o <= shift_bit;
      end
   end
endmodule : mirror_driver_spi_control

// ---- verification/mirror_driver_spi_control_asserts.sv ----
module mirror_spi_checker (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic logic_supply_ok_i,
   input wire logic wake_enable_i,
   input wire logic select_n_i,
   input wire logic serial_clk_i,
   input wire logic serial_out_o,
   input wire logic serial_out_oe_n_o,
   input wire logic outputs_oe_n_o,
   input wire logic heater_drive_o,
   input wire logic lamp_a_drive_o,
   input wire logic lamp_b_drive_o,
   input wire logic [5:0] bridge_drive_o,
   input wire logic test_mode_o,
   input wire logic [3:0] status_clear_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_n_i);
   a_sleep_switches_off: assert property ((!wake_enable_i)[*8] |->
      {heater_drive_o, lamp_a_drive_o, lamp_b_drive_o, bridge_drive_o} == 9'h0
      && outputs_oe_n_o) else $error("drives active in sleep");
   a_sleep_no_link: assert property ((!wake_enable_i)[*8] |->
      serial_out_oe_n_o) else $error("serial out driven in sleep");
   a_idle_out_float: assert property (select_n_i[*8] |->
      serial_out_oe_n_o) else $error("serial out driven while idle");
   a_select_drives_out: assert property ($fell(select_n_i) &&
      !outputs_oe_n_o |-> ##[2:8] !serial_out_oe_n_o)
      else $error("serial out not driven after select");
   a_out_stable_low: assert property (
      (!serial_clk_i && !select_n_i)[*8] |=> $stable(serial_out_o))
      else $error("serial out moved while clock low");
   a_control_holds: assert property ((select_n_i && wake_enable_i &&
      logic_supply_ok_i)[*8] |=> $stable(test_mode_o))
      else $error("control changed without frame");
   a_test_at_commit: assert property (!$stable(test_mode_o) |->
      select_n_i) else $error("control changed inside frame");
   a_clear_one_hot: assert property ($onehot0(status_clear_o))
      else $error("clear pulse not one-hot");
   a_clear_pulse_once: assert property (|status_clear_o |=>
      status_clear_o == 4'h0 && select_n_i)
      else $error("clear pulse too long");
   cover property ($fell(select_n_i) && !outputs_oe_n_o);
   cover property (|status_clear_o);
   cover property ($rose(test_mode_o));
endmodule : mirror_spi_checker

bind mirror_driver_spi_control mirror_spi_checker u_chk (.clock_i, .rst_n_i,
   .logic_supply_ok_i, .wake_enable_i, .select_n_i, .serial_clk_i,
   .serial_out_o, .serial_out_oe_n_o, .outputs_oe_n_o, .heater_drive_o,
   .lamp_a_drive_o, .lamp_b_drive_o, .bridge_drive_o, .test_mode_o,
   .status_clear_o);

// ---- verification/spi_master_model.sv ----
module spi_master_model (
   input wire logic serial_out_i,
   input wire logic serial_out_oe_n_i,
   output logic select_n_o,
   output logic serial_clk_o,
   output logic serial_in_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic last_bit = 1'b0;
   // A released line has no pull, so it shows the inverse of its last bit.
   wire logic line = serial_out_oe_n_i ? ~last_bit : serial_out_i;
   initial begin
      select_n_o = 1'b1;
      serial_clk_o = 1'b0;
      serial_in_o = 1'b0;
   end
   always @(serial_out_i or serial_out_oe_n_i) begin
      if (!serial_out_oe_n_i) last_bit = serial_out_i;
   end
   task automatic xfer(input int n, input logic [31:0] tx,
                       output logic [31:0] rx);
      rx = 32'h0;
      select_n_o = 1'b0;
      #320;
      for (int i = n - 1; i >= 0; i--) begin
         serial_in_o = tx[i];
         serial_clk_o = 1'b1;
         #160;
         serial_clk_o = 1'b0;
         rx[i] = line;
         #160;
      end
      select_n_o = 1'b1;
      serial_in_o = ~serial_in_o;
      #160;
   endtask : xfer
endmodule : spi_master_model

// ---- verification/mirror_driver_spi_control_tb.sv ----
module mirror_driver_spi_control_tb import mirror_spi_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic supply_ok = 1'b0, wake = 1'b0, pwm_in_1 = 1'b0, pwm_in_2 = 1'b0;
   logic [15:0] st [4];
   wire logic sel_n, sclk, sdi;
   logic sdo, sdo_oe_n, oe_n, htr, lpa, lpb, tm;
   logic [5:0] brg;
   logic [2:0] opl;
   logic [3:0] clr, clr_seen;
   sense_route_t route;
   int mismatches = 0, cmp_count = 0;
   integer seed = 80;
   int ctl [4];
   int addr_prev, clr_arm, clr_idx, sense_code;
   logic [31:0] r;
   always #10 clock_i = ~clock_i;
   always @(posedge clock_i) clr_seen <= clr_seen | clr;
   mirror_driver_spi_control DUT (.clock_i(clock_i), .rst_n_i(rst_n_i),
      .logic_supply_ok_i(supply_ok), .wake_enable_i(wake),
      .select_n_i(sel_n), .serial_clk_i(sclk), .serial_in_i(sdi),
      .pwm_in_1_i(pwm_in_1), .pwm_in_2_i(pwm_in_2), .status_word_0_i(st[0]),
      .status_word_1_i(st[1]), .status_word_2_i(st[2]),
      .status_word_3_i(st[3]), .serial_out_o(sdo),
      .serial_out_oe_n_o(sdo_oe_n), .outputs_oe_n_o(oe_n),
      .heater_drive_o(htr), .lamp_a_drive_o(lpa), .lamp_b_drive_o(lpb),
      .bridge_drive_o(brg), .openload_pullup_o(opl), .test_mode_o(tm),
      .sense_route_o(route), .status_clear_o(clr));
   spi_master_model master (.serial_out_i(sdo), .serial_out_oe_n_i(sdo_oe_n),
      .select_n_o(sel_n), .serial_clk_o(sclk), .serial_in_o(sdi));
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // A switch follows its picked PWM inputs when any pick is set.
   function automatic logic drv(input int b, input int on);
      if (ctl[1][b] | ctl[3][b])
         return (ctl[1][b] & pwm_in_1) | (ctl[3][b] & pwm_in_2);
      return on[0];
   endfunction : drv
   task automatic check_outputs();
      chk(oe_n, 1'b0);
      chk({htr, lpa, lpb}, {drv(15, ctl[0] >> 9),
         drv(14, ctl[2] >> 9), drv(12, ctl[2] >> 7)});
      chk(brg, ctl[2][15:10]);
      chk(opl, {ctl[3][6], ctl[3][7], ctl[1][7]});
      chk(tm, |ctl[0][8:6] | ctl[1][6]);
      chk(route, sense_code == 3 ? 1 : sense_code == 4 ? 2 : 0);
   endtask : check_outputs
   task automatic frame(input int n, input logic [31:0] tx);
      logic [31:0] rx;
      @(negedge clock_i);
      pwm_in_1 = 1'($random(seed));
      pwm_in_2 = 1'($random(seed));
      foreach (st[i]) st[i] = 16'($random(seed));
      clr_seen = 4'h0;
      master.xfer(n, tx, rx);
      repeat (12) @(negedge clock_i);
      chk(sdo_oe_n, 1'b1);
      if (n == 24) chk(rx[7:0], tx[23:16]);
      if (n >= 16) begin
         chk(rx[n-1 -: 16], st[addr_prev]);
         chk(clr_seen, clr_arm ? 4'h1 << clr_idx : 4'h0);
         clr_arm = tx[2];
         clr_idx = tx[1:0];
         ctl[tx[1:0]] = tx[15:0];
         sense_code = tx[5:3];
         addr_prev = tx[1:0];
      end else begin
         chk(clr_seen, 4'h0);
      end
      check_outputs();
   endtask : frame
   task automatic power_cycle(input bit by_wake);
      logic [31:0] rx;
      @(negedge clock_i);
      if (by_wake) wake = 1'b0;
      else supply_ok = 1'b0;
      repeat (12) @(negedge clock_i);
      chk(oe_n, 1'b1);
      if (by_wake) begin
         chk({htr, lpa, lpb, brg}, 9'h000);
         master.xfer(16, 32'h0000FFFE, rx);
      end
      wake = 1'b1;
      supply_ok = 1'b1;
      foreach (ctl[i]) ctl[i] = 0;
      addr_prev = 0;
      clr_arm = 0;
      sense_code = 0;
      repeat (12) @(negedge clock_i);
      check_outputs();
   endtask : power_cycle
   initial begin
      foreach (st[i]) st[i] = 16'h0000;
      foreach (ctl[i]) ctl[i] = 0;
      addr_prev = 0;
      clr_arm = 0;
      clr_idx = 0;
      sense_code = 0;
      clr_seen = 4'h0;
      repeat (16) @(negedge clock_i);
      rst_n_i = 1'b1;
      repeat (6) @(negedge clock_i);
      supply_ok = 1'b1;
      wake = 1'b1;
      repeat (12) @(negedge clock_i);
      check_outputs();
      for (int i = 0; i < 16; i++) begin
         r = $random(seed);
         frame(16, {16'h0, r[15:6], i[2:0], r[2], i[1:0]});
      end
      r = $random(seed);
      frame(24, {8'h00, r[23:0]});
      frame(8, {24'h0, r[31:24]});
      power_cycle(1'b1);
      frame(16, 32'h0000FFC6);
      power_cycle(1'b0);
      frame(16, 32'h0000FFC2);
      frame(16, 32'h00000000);
      frame(16, 32'h00000001);
      print_verdict();
   end
   initial begin
      #1000000;
      mismatches++;
      print_verdict();
   end
endmodule : mirror_driver_spi_control_tb
